// [logic/tpgd_params.svh]
// Behaviour
// (R1) Gate outputs need both enables high.
// (R2) High-side command input is active low.
// (R3) Low-side command input is active high.
// (R4) Serial input sampled on falling clock, MSB first.
// (R5) Serial output undriven while chip select high.
// (R6) Chip select frames transfers, enables port.
// (R7) Phase flag low below half supply.
// (R8) Host runs serial clock near 3.0 MHz; the host model runs it at 8 MHz (25 system clocks per bit).
// (R9) Reset input holds all gate outputs off.
`ifndef TPGD_PARAMS_SVH
`define TPGD_PARAMS_SVH

// Serial frame length and bit counter width.
`define TPGD_FRAME_BITS 5'h10
`define TPGD_CNT_W 5

// Typical serial clock rate and the system clock rate, both in kHz.
`define TPGD_SCLK_TYP_KHZ 3000
`define TPGD_CLK_SYS_KHZ 200000
// System clock cycles per typical serial clock period, rounded down.
`define TPGD_SCLK_TYP_CYC (`TPGD_CLK_SYS_KHZ / `TPGD_SCLK_TYP_KHZ)

// Number of filtered pin inputs.
`define TPGD_PIN_W 16

// Reset values.
`define TPGD_GATE_RST 3'h0
`define TPGD_WORD_RST 16'h0000
// Idle level of every filtered pin: high-side commands, reset pin and chip select high.
`define TPGD_PINS_RST 16'h38C0

`endif

// [logic/tpgd_pkg.sv]
package tpgd_pkg;

  // Bundle of filtered pin inputs, one bit each unless noted.
  typedef struct packed {
    logic en_a;
    logic en_b;
    logic [2:0] high_cmd_n;
    logic [2:0] low_cmd;
    logic chip_rst_n;
    logic cs_n;
    logic sclk;
    logic si;
    logic [2:0] cmp_above;
    logic oc_trip;
  } tpgd_pins_s;

  // Gate drive command bundle.
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } tpgd_gate_s;

  // Serial shift word.
  typedef logic [15:0] tpgd_word_t;

endpackage

// [logic/tpgd_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpgd_params.svh"

module tpgd_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Drive enables and reset pin.
  input wire logic drive_enable_a,
  input wire logic drive_enable_b,
  input wire logic chip_reset_n,
  // Phase commands.
  input wire logic phase1_high_cmd_n,
  input wire logic phase2_high_cmd_n,
  input wire logic phase3_high_cmd_n,
  input wire logic phase1_low_cmd,
  input wire logic phase2_low_cmd,
  input wire logic phase3_low_cmd,
  // Comparator results, high when the high source is above half supply.
  input wire logic phase1_high_source,
  input wire logic phase2_high_source,
  input wire logic phase3_high_source,
  input wire logic overcurrent_trip,
  // Serial port.
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  // Received command word.
  output logic [15:0] rx_word,
  output logic rx_valid,
  // Gate drive commands.
  output logic [2:0] gate_high,
  output logic [2:0] gate_low,
  // Status outputs.
  output logic phase1_level_flag,
  output logic phase2_level_flag,
  output logic phase3_level_flag,
  output logic overcurrent_flag
);

  tpgd_pkg::tpgd_pins_s raw_pins;
  logic [`TPGD_PIN_W-1:0] sync1_q;
  logic [`TPGD_PIN_W-1:0] sync2_q;
  logic [`TPGD_PIN_W-1:0] sync3_q;
  logic [`TPGD_PIN_W-1:0] filt_q;
  tpgd_pkg::tpgd_pins_s pins;
  tpgd_pkg::tpgd_gate_s gate_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic drive_ok;
  tpgd_pkg::tpgd_word_t rx_shift_q;
  tpgd_pkg::tpgd_word_t tx_shift_q;
  logic [`TPGD_CNT_W-1:0] bit_cnt_q;
  tpgd_pkg::tpgd_word_t rx_word_q;
  logic rx_valid_q;
  logic so_q;
  logic so_oe_q;
  logic [2:0] level_q;
  logic oc_q;

  // Gather the asynchronous pins into one bundle.
  assign raw_pins = '{en_a: drive_enable_a, en_b: drive_enable_b,
                      high_cmd_n: {phase3_high_cmd_n, phase2_high_cmd_n, phase1_high_cmd_n},
                      low_cmd: {phase3_low_cmd, phase2_low_cmd, phase1_low_cmd},
                      chip_rst_n: chip_reset_n, cs_n: spi_cs_n, sclk: spi_sclk, si: spi_si,
                      cmp_above: {phase3_high_source, phase2_high_source, phase1_high_source},
                      oc_trip: overcurrent_trip};

  // Three sync flops and a filter flop per pin; a change is taken once the last two sync flops agree.
  // The chain resets to the pins' idle levels so that no false chip select edge follows reset.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_q <= `TPGD_PINS_RST;
      sync2_q <= `TPGD_PINS_RST;
      sync3_q <= `TPGD_PINS_RST;
      filt_q <= `TPGD_PINS_RST;
    end else begin
      sync1_q <= raw_pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
    end
  end

  assign pins = filt_q;

  // Edge detection on the filtered serial clock and chip select.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= pins.sclk;
      cs_prev_q <= pins.cs_n;
    end
  end

  assign sclk_fall = sclk_prev_q & ~pins.sclk;
  assign sclk_rise = ~sclk_prev_q & pins.sclk;
  assign cs_fall = cs_prev_q & ~pins.cs_n;
  assign cs_rise = ~cs_prev_q & pins.cs_n;

  // Drive is allowed only with both enables high and the reset pin released.
  assign drive_ok = pins.en_a & pins.en_b & pins.chip_rst_n; // R1 R9

  // Gate drive commands.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      gate_q <= '0;
    end else if (drive_ok) begin
      gate_q.high <= ~pins.high_cmd_n; // R2
      gate_q.low <= pins.low_cmd; // R3
    end else begin
      gate_q.high <= `TPGD_GATE_RST; // R1 R9
      gate_q.low <= `TPGD_GATE_RST;
    end
  end

  // Receive shift register and bit counter, active only inside a frame.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift_q <= `TPGD_WORD_RST;
      bit_cnt_q <= '0;
    end else if (cs_fall) begin
      bit_cnt_q <= '0; // R6
    end else if (!pins.cs_n && sclk_fall) begin
      rx_shift_q <= {rx_shift_q[14:0], pins.si}; // R4
      if (bit_cnt_q != `TPGD_FRAME_BITS) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // A frame of the full length or longer delivers a word when chip select rises.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_word_q <= `TPGD_WORD_RST;
      rx_valid_q <= 1'b0;
    end else begin
      rx_valid_q <= cs_rise && (bit_cnt_q == `TPGD_FRAME_BITS); // R6
      if (cs_rise && (bit_cnt_q == `TPGD_FRAME_BITS)) begin
        rx_word_q <= rx_shift_q;
      end
    end
  end

  // Transmit status word, loaded at frame start, advanced on rising clock.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_shift_q <= `TPGD_WORD_RST;
      so_q <= 1'b0;
    end else if (cs_fall) begin
      tx_shift_q <= {rx_word_q[7:0], 2'h0, drive_ok, pins.oc_trip, pins.cmp_above, 1'b0};
      so_q <= rx_word_q[7];
    end else if (!pins.cs_n && sclk_rise) begin
      // Each rising clock presents the next bit, so the first rise shows the MSB
      // and the host's falling-edge sample never misses it.
      tx_shift_q <= {tx_shift_q[14:0], 1'b0};
      so_q <= tx_shift_q[15];
    end
  end

  // Serial output is driven only while chip select is low.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= ~pins.cs_n; // R5
    end
  end

  // Comparator status outputs, low when the source is below half supply.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      level_q <= 3'h0;
      oc_q <= 1'b0;
    end else begin
      level_q <= pins.cmp_above; // R7
      oc_q <= pins.oc_trip;
    end
  end

  assign gate_high = gate_q.high;
  assign gate_low = gate_q.low;
  assign spi_so = so_q;
  assign spi_so_oe = so_oe_q;
  assign rx_word = rx_word_q;
  assign rx_valid = rx_valid_q;
  assign phase1_level_flag = level_q[0];
  assign phase2_level_flag = level_q[1];
  assign phase3_level_flag = level_q[2];
  assign overcurrent_flag = oc_q;

  // Checks on the gate path, the serial port and the phase flags.
  a_gate_needs_both: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
    (|{gate_q.high, gate_q.low}) |-> $past(pins.en_a) && $past(pins.en_b))
    else $error("Gate driven without both enables.");

  a_gate_off_disabled: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
    !(pins.en_a && pins.en_b) |=> (gate_q.high == 3'h0) && (gate_q.low == 3'h0))
    else $error("Gate not off while an enable is low.");

  a_high_active_low: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
    drive_ok |=> gate_q.high == ~$past(pins.high_cmd_n))
    else $error("High-side gate does not follow inverted command.");

  a_low_active_high: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
    drive_ok |=> gate_q.low == $past(pins.low_cmd))
    else $error("Low-side gate does not follow command.");

  a_reset_pin_off: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
    !pins.chip_rst_n [*2] |-> (gate_q.high == 3'h0) && (gate_q.low == 3'h0))
    else $error("Gate driven while reset pin asserted.");

  a_rx_fall_msb: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
    (!pins.cs_n && sclk_fall && !cs_fall) |=>
      (rx_shift_q[0] == $past(pins.si)) && (rx_shift_q[15:1] == $past(rx_shift_q[14:0])))
    else $error("Serial input not shifted in on falling clock.");

  a_so_hiz_cs_high: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
    pins.cs_n |=> !so_oe_q ##1 (!so_oe_q || !pins.cs_n))
    else $error("Serial output driven while chip select high.");

  a_port_framed: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
    (pins.cs_n && !cs_rise) |=> $stable(rx_shift_q) && !rx_valid_q)
    else $error("Serial port active outside a frame.");

  a_level_flag: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
    ##1 level_q == $past(pins.cmp_above))
    else $error("Phase flag does not follow comparator.");

  c_frame_done: cover property (@(posedge clk_sys) disable iff (sys_rst) rx_valid_q);
  c_gate_on: cover property (@(posedge clk_sys) disable iff (sys_rst) |gate_q.high);
  c_so_driven: cover property (@(posedge clk_sys) disable iff (sys_rst) so_oe_q && so_q);

endmodule
`default_nettype wire

// [tb/tpgd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial port: frames every transfer with chip select.
module tpgd_host_model (
  // Clock that times the serial edges.
  input wire logic clk_sys,
  // Serial lines.
  input wire logic spi_so,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_si
);
  // Idle with chip select high and the serial clock parked low.
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si = 1'b0;
  end

  // Sends the top n bits of w MSB first and collects what the device shifts out.
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] got);
    got = 16'h0000;
    @(negedge clk_sys);
    spi_cs_n = 1'b0;
    repeat (12) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(negedge clk_sys);
      spi_si = w[15 - i];
      repeat (6) @(negedge clk_sys);
      spi_sclk = 1'b1;
      repeat (13) @(negedge clk_sys);
      spi_sclk = 1'b0;
      got = {got[14:0], spi_so};
    end
    repeat (12) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    spi_si = ~spi_si;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic en_a = 1'b0;
  logic en_b = 1'b0;
  logic rst_n = 1'b1;
  logic [2:0] hcmd_n = 3'h7;
  logic [2:0] lcmd = 3'h0;
  logic [2:0] src = 3'h0;
  logic oc = 1'b0;
  wire logic cs_n, sclk, si, so, so_oe, rx_valid, f1, f2, f3, ocf;
  wire logic [15:0] rx_word;
  wire logic [2:0] gh, gl;
  int err_count = 0;
  int n_compared = 0;

  // System clock at 200 MHz.
  always #2.5 clk_sys = ~clk_sys;

  tpgd_host_model i_host (.clk_sys(clk_sys), .spi_so(so), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_si(si));

  tpgd_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .drive_enable_a(en_a),
    .drive_enable_b(en_b), .chip_reset_n(rst_n), .phase1_high_cmd_n(hcmd_n[0]),
    .phase2_high_cmd_n(hcmd_n[1]), .phase3_high_cmd_n(hcmd_n[2]),
    .phase1_low_cmd(lcmd[0]), .phase2_low_cmd(lcmd[1]), .phase3_low_cmd(lcmd[2]),
    .phase1_high_source(src[0]), .phase2_high_source(src[1]),
    .phase3_high_source(src[2]), .overcurrent_trip(oc), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe), .rx_word(rx_word),
    .rx_valid(rx_valid), .gate_high(gh), .gate_low(gl), .phase1_level_flag(f1),
    .phase2_level_flag(f2), .phase3_level_flag(f3), .overcurrent_flag(ocf));

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Gate outputs for every enable pair and both command patterns.
  task automatic t_gates();
    logic on;
    for (int p = 0; p < 2; p++) begin
      for (int e = 0; e < 8; e++) begin
        @(negedge clk_sys);
        {rst_n, en_b, en_a} = e[2:0];
        hcmd_n = p[0] ? 3'h2 : 3'h5;
        lcmd = p[0] ? 3'h4 : 3'h3;
        on = &e[2:0];
        repeat (10) @(negedge clk_sys);
        chk({13'h0, gh}, {13'h0, ~hcmd_n & {3{on}}}, "gate high");
        chk({13'h0, gl}, {13'h0, lcmd & {3{on}}}, "gate low");
      end
    end
  endtask

  // Phase and overcurrent flags follow their comparators.
  task automatic t_flags();
    for (int v = 0; v < 16; v += 5) begin
      @(negedge clk_sys);
      {oc, src} = v[3:0];
      repeat (10) @(negedge clk_sys);
      chk({12'h0, ocf, f3, f2, f1}, {12'h0, v[3:0]}, "flags");
    end
  endtask

  // Watches a short span after a frame for the completion pulse.
  task automatic wait_valid(output logic seen);
    seen = 1'b0;
    repeat (20) begin
      @(negedge clk_sys);
      if (rx_valid === 1'b1) seen = 1'b1;
    end
  endtask

  // Two full frames back to back, then a short one that must be dropped.
  task automatic t_serial();
    logic [15:0] got;
    logic seen;
    chk({15'h0, so_oe}, 16'h0000, "so idle");
    i_host.frame(16'hA5C3, 16, got);
    wait_valid(seen);
    chk({15'h0, seen}, 16'h0001, "valid 1");
    chk(rx_word, 16'hA5C3, "word 1");
    chk({15'h0, so_oe}, 16'h0000, "so released");
    i_host.frame(16'h3C5A, 16, got);
    wait_valid(seen);
    chk({15'h0, seen}, 16'h0001, "valid 2");
    chk(rx_word, 16'h3C5A, "word 2");
    chk(got, 16'hC33E, "echo and status");
    i_host.frame(16'hFF00, 8, got);
    wait_valid(seen);
    chk({15'h0, seen}, 16'h0000, "short frame");
    chk(rx_word, 16'h3C5A, "word kept");
  endtask

  // Cuts a hang short.
  initial begin
    #20000;
    err_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    t_gates();
    t_flags();
    t_serial();
    report_and_stop();
  end
endmodule
`default_nettype wire
